/* File: verilog/tdc_pkg.sv */
// package: widths, reset values and carrier types for the tti config handler
package tdc_pkg;
    localparam int unsigned TDC_SFN_W = 10;
    localparam int unsigned TDC_TTI_W = 4;
    localparam int unsigned TDC_CFG_W = 64;
    localparam logic [TDC_SFN_W-1:0] TDC_SFN_LAST = 10'h3ff;
    localparam logic [TDC_TTI_W-1:0] TDC_TTI_LAST = 4'h9;
    localparam logic [TDC_SFN_W-1:0] TDC_SFN_RST = 10'h000;
    localparam logic [TDC_TTI_W-1:0] TDC_TTI_RST = 4'h0;
    localparam logic [TDC_CFG_W-1:0] TDC_CFG_EMPTY = 64'h0000_0000_0000_0000;
    localparam logic TDC_RT_MODE_RST = 1'b0;

    // timing indication word pushed toward the host
    typedef struct packed {
        logic [TDC_SFN_W-1:0] sfn;
        logic [TDC_TTI_W-1:0] tti;
    } tdc_timing_type;

    // configuration handed to both encoders
    typedef struct packed {
        logic valid;
        logic fresh;
        logic [TDC_CFG_W-1:0] cfg;
    } tdc_enc_cfg_type;
endpackage : tdc_pkg

/* File: verilog/tdc_tti_config.sv */
// tti handler: timing indication out, dynamic dl configuration in
// Function
// - each subframe trigger pushes a timing indication for the next subframe
// - next trigger reads that configuration and forwards it to both encoders
// - real-time mode with nothing available: encoders get an empty configuration
// - tolerant mode with nothing available: last configuration is reused
// - real-time mode is cleared after reset
`timescale 1ns/10ps
`default_nettype none
module tdc_tti_config
    import tdc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic subframe_trig_i,
    input wire logic realtime_host_mode_i,
    input wire logic realtime_host_mode_load_i,
    output logic timing_indication_out_fifo_valid_o,
    output tdc_timing_type timing_indication_out_fifo_data_o,
    input wire logic timing_indication_out_fifo_ready_i,
    input wire logic dl_config_in_fifo_valid_i,
    input wire logic [TDC_CFG_W-1:0] dl_config_in_fifo_data_i,
    output logic dl_config_in_fifo_ready_o,
    output tdc_enc_cfg_type pdcch_cfg_o,
    output tdc_enc_cfg_type pdsch_cfg_o,
    output logic realtime_host_mode_o,
    output logic indication_drop_o
);
    logic rt_mode_ff;
    logic [TDC_SFN_W-1:0] sfn_ff;
    logic [TDC_TTI_W-1:0] tti_ff;
    logic [TDC_SFN_W-1:0] nxt_sfn;
    logic [TDC_TTI_W-1:0] nxt_tti;
    logic ind_valid_ff;
    tdc_timing_type ind_data_ff;
    logic drop_ff;
    logic [TDC_CFG_W-1:0] hold_ff;
    logic hold_new_ff;
    logic ready_ff;
    tdc_enc_cfg_type enc_ff;
    tdc_enc_cfg_type nxt_enc;
    logic take;

    // mode bit, loaded by strobe from the host side control path
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rt_mode_ff <= TDC_RT_MODE_RST;
        end else if (realtime_host_mode_load_i) begin
            rt_mode_ff <= realtime_host_mode_i;
        end
    end

    // subframe counter: current subframe advances on each trigger
    always_comb begin
        nxt_tti = tti_ff + 4'h1;
        nxt_sfn = sfn_ff;
        if (tti_ff == TDC_TTI_LAST) begin
            nxt_tti = TDC_TTI_RST;
            nxt_sfn = (sfn_ff == TDC_SFN_LAST) ? TDC_SFN_RST
                                               : sfn_ff + 10'h001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sfn_ff <= TDC_SFN_RST;
            tti_ff <= TDC_TTI_RST;
        end else if (subframe_trig_i) begin
            sfn_ff <= nxt_sfn;
            tti_ff <= nxt_tti;
        end
    end

    // one-entry indication slot; a fresh trigger overwrites a stale one so
    // the host always sees the latest subframe, and the loss is flagged
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ind_valid_ff <= 1'b0;
            ind_data_ff <= '0;
            drop_ff <= 1'b0;
        end else begin
            drop_ff <= subframe_trig_i && ind_valid_ff
                       && !timing_indication_out_fifo_ready_i;
            if (subframe_trig_i) begin
                ind_valid_ff <= 1'b1;
                ind_data_ff.sfn <= nxt_sfn;
                ind_data_ff.tti <= nxt_tti;
            end else if (timing_indication_out_fifo_ready_i) begin
                ind_valid_ff <= 1'b0;
            end
        end
    end

    // drain incoming fifo continuously into the holding register; only the
    // newest word matters, older ones are overwritten before the trigger
    assign take = dl_config_in_fifo_valid_i && ready_ff;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hold_ff <= TDC_CFG_EMPTY;
            hold_new_ff <= 1'b0;
        end else begin
            if (take) begin
                hold_ff <= dl_config_in_fifo_data_i;
            end
            // arrival in the trigger cycle is kept for the next subframe
            if (take) begin
                hold_new_ff <= 1'b1;
            end else if (subframe_trig_i) begin
                hold_new_ff <= 1'b0;
            end
        end
    end

    // encoder configuration chosen at the trigger
    always_comb begin
        nxt_enc = enc_ff;
        if (subframe_trig_i) begin
            nxt_enc.valid = 1'b1;
            nxt_enc.fresh = hold_new_ff;
            if (hold_new_ff) begin
                nxt_enc.cfg = hold_ff;
            end else if (rt_mode_ff) begin
                nxt_enc.cfg = TDC_CFG_EMPTY;
            end else begin
                nxt_enc.cfg = hold_ff;
            end
        end else begin
            nxt_enc.valid = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            enc_ff <= '0;
        end else begin
            enc_ff <= nxt_enc;
        end
    end

    assign timing_indication_out_fifo_valid_o = ind_valid_ff;
    assign timing_indication_out_fifo_data_o = ind_data_ff;
    assign dl_config_in_fifo_ready_o = ready_ff;
    assign pdcch_cfg_o = enc_ff;
    assign pdsch_cfg_o = enc_ff;
    assign realtime_host_mode_o = rt_mode_ff;
    assign indication_drop_o = drop_ff;

    mode_reset_a: assert property (@(posedge clock_i)
        !rst_n_i |=> !rt_mode_ff)
        else $error("real-time mode not cleared by reset");

    ind_push_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        subframe_trig_i |=> ind_valid_ff
            && ind_data_ff.tti == tti_ff && ind_data_ff.sfn == sfn_ff)
        else $error("timing indication not for next subframe");

    cfg_forward_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        subframe_trig_i && hold_new_ff |=> enc_ff.valid
            && enc_ff.cfg == $past(hold_ff))
        else $error("received configuration not forwarded");

    rt_empty_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        subframe_trig_i && !hold_new_ff && rt_mode_ff
            |=> enc_ff.cfg == TDC_CFG_EMPTY && !enc_ff.fresh)
        else $error("missing configuration not emptied");

    reuse_last_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        subframe_trig_i && !hold_new_ff && !rt_mode_ff
            |=> enc_ff.cfg == $past(hold_ff) && !enc_ff.fresh)
        else $error("last configuration not reused");

    hold_keep_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ready_ff && dl_config_in_fifo_valid_i
            |=> hold_ff == $past(dl_config_in_fifo_data_i) && hold_new_ff)
        else $error("holding register missed a word");

    cfg_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !subframe_trig_i |=> !enc_ff.valid)
        else $error("encoder strobe without trigger");

    fifo_take_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        rst_n_i ##1 rst_n_i |-> dl_config_in_fifo_ready_o)
        else $error("incoming fifo not drained");

    tti_range_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        tti_ff <= TDC_TTI_LAST)
        else $error("subframe index out of range");

    // wrap is never reached by the short bench runs, so guard it here
    tti_wrap_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        subframe_trig_i && tti_ff == TDC_TTI_LAST
            |=> tti_ff == TDC_TTI_RST && sfn_ff != $past(sfn_ff))
        else $error("subframe index did not wrap");

    ind_next_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        subframe_trig_i && tti_ff != TDC_TTI_LAST
            |=> ind_data_ff.tti == $past(tti_ff) + 4'h1
                && ind_data_ff.sfn == $past(sfn_ff))
        else $error("indication does not name next subframe");

    ind_stand_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ind_valid_ff && !timing_indication_out_fifo_ready_i
            |=> ind_valid_ff)
        else $error("indication lost before fifo accepted it");

    fresh_keep_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        subframe_trig_i && take |=> hold_new_ff)
        else $error("arrival at trigger not kept for next subframe");
endmodule : tdc_tti_config
`default_nettype wire

/* File: bench/tdc_host_model.sv */
// host model: reads timing indications, answers with a configuration word
`timescale 1ns/10ps
`default_nettype none
module tdc_host_model
    import tdc_pkg::*;
#(
    parameter int DELAY = 3
)
(
    input wire logic clock_i,
    input wire logic reply_en_i,
    input wire logic stall_i,
    input wire logic ind_valid_i,
    input wire tdc_timing_type ind_data_i,
    output logic ind_ready_o,
    output logic cfg_valid_o,
    input wire logic cfg_ready_i,
    output logic [TDC_CFG_W-1:0] cfg_data_o
);
    int cnt = -1;
    tdc_timing_type seen;
    initial begin
        cfg_valid_o = 1'b0;
        cfg_data_o = '1;
    end
    always @(posedge clock_i) begin
        ind_ready_o <= !stall_i;
        // word stands until taken; then data flips so it never looks fresh
        if (cfg_valid_o && cfg_ready_i) begin
            cfg_valid_o <= 1'b0;
            cfg_data_o <= ~cfg_data_o;
        end
        if (ind_valid_i && ind_ready_o && reply_en_i) begin
            seen <= ind_data_i;
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0 && !cfg_valid_o) begin
            cfg_valid_o <= 1'b1;
            cfg_data_o <= {50'h0_0000_0000_0000, seen};
            cnt <= -1;
        end
    end
endmodule : tdc_host_model
`default_nettype wire

/* File: bench/tb.sv */
// testbench: indication, config forwarding and mode fallbacks
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tdc_pkg::*;
    logic clock_i = 0;
    logic rst_n_i = 0;
    logic trig = 0;
    logic mode = 0;
    logic load = 0;
    logic reply = 0;
    logic stall = 0;
    logic iv, ir, cv, cr, mode_o, drop;
    tdc_timing_type id;
    logic [TDC_CFG_W-1:0] cd;
    tdc_enc_cfg_type pc, ps;
    int err_total = 0;
    int n_compared = 0;
    logic [3:0] tti = 4'h0;
    logic [49:0] pad = 50'h0_0000_0000_0000;
    initial forever #50 clock_i = ~clock_i;
    tdc_tti_config i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .subframe_trig_i(trig), .realtime_host_mode_i(mode),
        .realtime_host_mode_load_i(load),
        .timing_indication_out_fifo_valid_o(iv),
        .timing_indication_out_fifo_data_o(id),
        .timing_indication_out_fifo_ready_i(ir),
        .dl_config_in_fifo_valid_i(cv), .dl_config_in_fifo_data_i(cd),
        .dl_config_in_fifo_ready_o(cr), .pdcch_cfg_o(pc), .pdsch_cfg_o(ps),
        .realtime_host_mode_o(mode_o), .indication_drop_o(drop));
    tdc_host_model i_host (.clock_i(clock_i), .reply_en_i(reply),
        .stall_i(stall), .ind_valid_i(iv), .ind_data_i(id),
        .ind_ready_o(ir), .cfg_valid_o(cv), .cfg_ready_i(cr),
        .cfg_data_o(cd));
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // one trigger; encoder pulse must come within four cycles
    task automatic fire(input logic fresh, input logic [63:0] cfg);
        tdc_timing_type ind;
        tdc_enc_cfg_type ea, eb;
        ind = '0;
        ea = '0;
        eb = '0;
        tti++;
        repeat (10) @(negedge clock_i);
        trig = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(negedge clock_i);
            trig = 1'b0;
            if (iv === 1'b1) begin
                ind = id;
            end
            if (pc.valid === 1'b1) begin
                ea = pc;
                eb = ps;
            end
        end
        chk(ind, {10'h000, tti});
        chk(ea, {1'b1, fresh, cfg});
        chk(eb, {1'b1, fresh, cfg});
        if (ea.valid !== 1'b1) begin
            results();
        end
    endtask : fire
    // back-pressure: indication stands, a second trigger overwrites it
    task automatic stall_drop();
        logic seen;
        seen = 1'b0;
        stall = 1'b1;
        repeat (2) @(negedge clock_i);
        trig = 1'b1;
        tti++;
        @(negedge clock_i);
        trig = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(iv, 1'b1);
        chk(id, {10'h000, tti});
        trig = 1'b1;
        tti++;
        for (int k = 0; k < 2; k++) begin
            @(negedge clock_i);
            trig = 1'b0;
            if (drop === 1'b1) begin
                seen = 1'b1;
            end
        end
        chk(seen, 1'b1);
        chk(id, {10'h000, tti});
        stall = 1'b0;
        repeat (3) @(negedge clock_i);
        chk(iv, 1'b0);
    endtask : stall_drop
    initial begin
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk(mode_o, TDC_RT_MODE_RST);
        chk(cr, 1'b1);
        fire(1'b0, TDC_CFG_EMPTY);
        $display("test empty hold done");
        reply = 1'b1;
        fire(1'b0, TDC_CFG_EMPTY);
        reply = 1'b0;
        fire(1'b1, {pad, 10'h000, 4'h2});
        $display("test fresh config done");
        fire(1'b0, {pad, 10'h000, 4'h2});
        $display("test tolerant reuse done");
        stall_drop();
        $display("test indication drop done");
        @(negedge clock_i);
        mode = 1'b1;
        load = 1'b1;
        @(negedge clock_i);
        load = 1'b0;
        @(negedge clock_i);
        chk(mode_o, 1'b1);
        fire(1'b0, TDC_CFG_EMPTY);
        $display("test realtime empty done");
        results();
    end
endmodule : tb
`default_nettype wire
